// [rtl/rcp_pkg.sv]
// Purpose: Constants for the regulator configuration register pair.
// Assumes: 8-bit register port, one clock, synchronous reset.
// Notes: Register offsets are local to this block's port.
//
// Contract
// R01 - Phase field bits 6:4 decode 000, 100, 010, 110 as phases one to four.
// R02 - Source select bit 3 at 1 takes the target code from the setpoint register.
// R03 - Source select bit 3 at 0 takes the target code from the identification pins.
// R04 - Loop test is enabled only when bit 2 is 1 in both registers.
// R05 - While latch-off enable bit 1 is 1, current limit times out and latches off.
// R06 - With bit 1 at 0 in both registers, current limit never latches off.
// R07 - Each register is a read-write byte with a reset default, reading back the last write.
package rcp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] CFG_A_ADDR = 8'h00;
	localparam logic [7:0] CFG_B_ADDR = 8'h01;
	localparam logic [7:0] STATUS_ADDR = 8'h02;
	localparam logic [7:0] CFG_RESET = 8'h52;
	localparam int PHASE_MSB = 6;
	localparam int PHASE_LSB = 4;
	localparam int SRC_SEL_BIT = 3;
	localparam int LOOP_BIT = 2;
	localparam int LATCH_BIT = 1;
	localparam logic [2:0] PH1_CODE = 3'h0;
	localparam logic [2:0] PH2_CODE = 3'h4;
	localparam logic [2:0] PH3_CODE = 3'h2;
	localparam logic [2:0] PH4_CODE = 3'h6;
	localparam logic [1:0] PH1_IDX = 2'h0;
	localparam logic [1:0] PH2_IDX = 2'h1;
	localparam logic [1:0] PH3_IDX = 2'h2;
	localparam logic [1:0] PH4_IDX = 2'h3;
	localparam int LATCHOFF_CYCLES_DEF = 1024;
endpackage : rcp_pkg

// [rtl/rcp_phase_decode.sv]
// Purpose: Decode one phase field into a phase index.
// Assumes: Purely combinational, registered by the caller.
// Notes: Unlisted codes report not valid and index zero.
`timescale 1ns/10ps
`default_nettype none
module rcp_phase_decode (
	input wire logic [2:0] field, // Phase field of a config byte
	output logic [1:0] idx, // Phase index, 0 = phase one
	output logic valid // Field holds a listed code
);
	import rcp_pkg::*;
	always_comb begin
		idx = PH1_IDX;
		valid = 1'b1;
		case (field)
			PH1_CODE: idx = PH1_IDX; // R01
			PH2_CODE: idx = PH2_IDX; // R01
			PH3_CODE: idx = PH3_IDX; // R01
			PH4_CODE: idx = PH4_IDX; // R01
			default: valid = 1'b0;
		endcase
	end
endmodule : rcp_phase_decode
`default_nettype wire

// [rtl/rcp_regulator_config.sv]
// Purpose: Regulator configuration register pair and the controls it steers.
// Assumes: Register port strobes are one cycle; inputs synchronous to clk.
// Notes: Latch-off clears only on reset, like a power cycle.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module rcp_regulator_config #(
	parameter int VCODE_W = 8,
	parameter int TIMEOUT_CYCLES = rcp_pkg::LATCHOFF_CYCLES_DEF,
	parameter int CNT_W = 16
) (
	input wire logic clk, // 25 MHz clock
	input wire logic srst, // Synchronous reset, high
	input wire logic ce, // Clock enable, freezes state when low
	input wire logic [rcp_pkg::ADDR_W-1:0] reg_addr, // Register address
	input wire logic [rcp_pkg::DATA_W-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [rcp_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
	input wire logic [VCODE_W-1:0] output_voltage_setpoint_reg, // Programmed setpoint code
	input wire logic [VCODE_W-1:0] voltage_identification_inputs, // Identification pins
	input wire logic current_limit_active, // Output is in current limit
	output logic [VCODE_W-1:0] vout_target_code, // Selected voltage target
	output logic [1:0][1:0] phase_idx, // Phase index, [0] = A, [1] = B
	output logic [1:0] phase_valid, // Phase field holds a listed code
	output logic loop_test_enable, // Control-loop test active
	output logic latchoff_enable, // Current-limit timeout armed
	output logic latched_off // Output latched off
);
	import rcp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	logic [DATA_W-1:0] cfg_r [2];
	logic [DATA_W-1:0] rdata_r;
	logic [VCODE_W-1:0] target_r;
	logic [1:0][1:0] phase_idx_r;
	logic [1:0] phase_valid_r;
	logic loop_r;
	logic latch_en_r;
	logic latched_r;
	logic [CNT_W-1:0] lim_cnt_r;
	logic [CNT_W-1:0] lim_cnt_nxt;
	logic [1:0][1:0] dec_idx;
	logic [1:0] dec_valid;
	logic latch_en;
	logic timeout_hit;

	localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(TIMEOUT_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////
	// Config registers, one per entry
	generate
		for (genvar i = 0; i < 2; i++) begin : g_cfg
			localparam logic [7:0] MY_ADDR = (i == 0) ? CFG_A_ADDR : CFG_B_ADDR;
			always_ff @(posedge clk) begin
				if (srst) begin
					cfg_r[i] <= CFG_RESET; // R07
				end else if (ce && reg_wr && reg_addr == MY_ADDR) begin
					cfg_r[i] <= reg_wdata; // R07
				end
			end
			rcp_phase_decode u_dec (
				.field(cfg_r[i][PHASE_MSB:PHASE_LSB]),
				.idx(dec_idx[i]),
				.valid(dec_valid[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Read port; data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_r <= 8'h00;
		end else if (ce) begin
			rdata_r <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					CFG_A_ADDR: rdata_r <= cfg_r[0]; // R07
					CFG_B_ADDR: rdata_r <= cfg_r[1]; // R07
					STATUS_ADDR: rdata_r <= {2'h0, phase_valid_r, latched_r, latch_en_r,
						loop_r, current_limit_active};
					default: rdata_r <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Phase selection, registered from the decoders
	always_ff @(posedge clk) begin
		if (srst) begin
			phase_idx_r <= '0;
			phase_valid_r <= 2'h0;
		end else if (ce) begin
			phase_idx_r <= dec_idx; // R01
			phase_valid_r <= dec_valid; // R01
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Voltage target source; register A's select bit rules
	always_ff @(posedge clk) begin
		if (srst) begin
			target_r <= '0;
		end else if (ce) begin
			if (cfg_r[0][SRC_SEL_BIT]) begin
				target_r <= output_voltage_setpoint_reg; // R02
			end else begin
				target_r <= voltage_identification_inputs; // R03
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Loop test needs agreement of both registers
	always_ff @(posedge clk) begin
		if (srst) begin
			loop_r <= 1'b0;
		end else if (ce) begin
			loop_r <= cfg_r[0][LOOP_BIT] & cfg_r[1][LOOP_BIT]; // R04
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Current-limit timeout; disabling needs both bits clear
	assign latch_en = cfg_r[0][LATCH_BIT] | cfg_r[1][LATCH_BIT]; // R05 R06
	assign timeout_hit = latch_en && current_limit_active && lim_cnt_r == LAST_CNT;

	always_comb begin
		lim_cnt_nxt = lim_cnt_r;
		if (!latch_en || !current_limit_active) begin
			lim_cnt_nxt = '0; // R06
		end else if (lim_cnt_r != LAST_CNT) begin
			lim_cnt_nxt = lim_cnt_r + CNT_W'(1); // R05
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			lim_cnt_r <= '0;
			latch_en_r <= 1'b0;
		end else if (ce) begin
			lim_cnt_r <= lim_cnt_nxt;
			latch_en_r <= latch_en;
		end
	end

	// Sticky until reset, as a power cycle would clear it
	always_ff @(posedge clk) begin
		if (srst) begin
			latched_r <= 1'b0;
		end else if (ce && timeout_hit) begin
			latched_r <= 1'b1; // R05
		end
	end

	assign reg_rdata = rdata_r;
	assign vout_target_code = target_r;
	assign phase_idx = phase_idx_r;
	assign phase_valid = phase_valid_r;
	assign loop_test_enable = loop_r;
	assign latchoff_enable = latch_en_r;
	assign latched_off = latched_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_phase_two;
		@(posedge clk) disable iff (srst)
		ce && cfg_r[0][PHASE_MSB:PHASE_LSB] == PH2_CODE
		|=> phase_idx_r[0] == PH2_IDX && phase_valid_r[0];
	endproperty
	a_phase_two: assert property (p_phase_two) else $error("phase two misdecoded"); // R01

	property p_phase_four;
		@(posedge clk) disable iff (srst)
		ce && cfg_r[1][PHASE_MSB:PHASE_LSB] == PH4_CODE
		|=> phase_idx_r[1] == PH4_IDX && phase_valid_r[1];
	endproperty
	a_phase_four: assert property (p_phase_four) else $error("phase four misdecoded"); // R01

	property p_src_setpoint;
		@(posedge clk) disable iff (srst)
		ce && cfg_r[0][SRC_SEL_BIT] |=> target_r == $past(output_voltage_setpoint_reg);
	endproperty
	a_src_setpoint: assert property (p_src_setpoint) else $error("target not setpoint"); // R02

	property p_src_pins;
		@(posedge clk) disable iff (srst)
		ce && !cfg_r[0][SRC_SEL_BIT] |=> target_r == $past(voltage_identification_inputs);
	endproperty
	a_src_pins: assert property (p_src_pins) else $error("target not from pins"); // R03

	property p_loop_both;
		@(posedge clk) disable iff (srst)
		ce |=> loop_r == ($past(cfg_r[0][LOOP_BIT]) && $past(cfg_r[1][LOOP_BIT]));
	endproperty
	a_loop_both: assert property (p_loop_both) else $error("loop test enable wrong"); // R04

	property p_latch_cause;
		@(posedge clk) disable iff (srst)
		$rose(latched_r) |-> $past(latch_en && current_limit_active && lim_cnt_r == LAST_CNT);
	endproperty
	a_latch_cause: assert property (p_latch_cause) else $error("latch-off without timeout"); // R05

	property p_latch_fires;
		@(posedge clk) disable iff (srst)
		ce && timeout_hit |=> latched_r;
	endproperty
	a_latch_fires: assert property (p_latch_fires) else $error("timeout did not latch"); // R05

	property p_never_latch;
		@(posedge clk) disable iff (srst)
		!cfg_r[0][LATCH_BIT] && !cfg_r[1][LATCH_BIT] && !latched_r |=> !latched_r;
	endproperty
	a_never_latch: assert property (p_never_latch) else $error("latched while disabled"); // R06

	property p_write_read;
		@(posedge clk) disable iff (srst)
		ce && reg_wr && reg_addr == CFG_B_ADDR ##1 ce && reg_rd && reg_addr == CFG_B_ADDR
		|=> rdata_r == $past(reg_wdata, 2);
	endproperty
	a_write_read: assert property (p_write_read) else $error("readback mismatch"); // R07

	property p_reset_value;
		@(posedge clk) srst |=> cfg_r[0] == CFG_RESET && cfg_r[1] == CFG_RESET;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("reset default wrong"); // R07
endmodule : rcp_regulator_config
`default_nettype wire

// [dv/tb_rcp_regulator_config.sv]
// Purpose: Self-checking bench for the regulator configuration register pair.
// Assumes: Bench drives every port itself; a short latch-off timeout keeps the run brief.
// Notes: Table rows cover the decode and steering cases; awkward cases follow.
`timescale 1ns/10ps
`default_nettype none
module tb_rcp_regulator_config;
	import rcp_pkg::*;
	typedef struct packed {
		logic [7:0] a, b, sp, pins, vout;
		logic [3:0] ph;
		logic [1:0] pv;
		logic lp, le;
	} rcp_row_t;
	localparam int TMO = 8;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] setpoint = 8'h3A;
	logic [7:0] pins = 8'hC5;
	logic current_limit_active = 1'b0;
	logic [7:0] vout_target_code;
	logic [1:0][1:0] phase_idx;
	logic [1:0] phase_valid;
	logic loop_test_enable, latchoff_enable, latched_off;
	int mismatches = 0;
	int samples_checked = 0;
	// Fields: a, b, setpoint, pins, vout, phase idx {B,A}, valid, loop, latch
	rcp_row_t rows [5] = '{
		'{8'h0C, 8'h04, 8'h3A, 8'hC5, 8'h3A, 4'h0, 2'h3, 1'b1, 1'b0},
		'{8'h40, 8'h04, 8'h3A, 8'h81, 8'h81, 4'h1, 2'h3, 1'b0, 1'b0},
		'{8'h26, 8'h00, 8'h3A, 8'hC5, 8'hC5, 4'h2, 2'h3, 1'b0, 1'b1},
		'{8'h6A, 8'h66, 8'h17, 8'hC5, 8'h17, 4'hF, 2'h3, 1'b0, 1'b1},
		'{8'h50, 8'h02, 8'h3A, 8'h99, 8'h99, 4'h0, 2'h2, 1'b0, 1'b1}};

	always #20 clk = ~clk;

	rcp_regulator_config #(.TIMEOUT_CYCLES(TMO)) i_dut (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.output_voltage_setpoint_reg(setpoint),
		.voltage_identification_inputs(pins),
		.current_limit_active(current_limit_active),
		.vout_target_code(vout_target_code),
		.phase_idx(phase_idx),
		.phase_valid(phase_valid),
		.loop_test_enable(loop_test_enable),
		.latchoff_enable(latchoff_enable),
		.latched_off(latched_off)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	// Strobe drops one edge later, so calls never collide in one time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd

	// Write then read back with no idle cycle between the strobes
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, d);
	endtask : wr_rd

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		complete_run();
	end

	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rd(CFG_A_ADDR, CFG_RESET);
		@(posedge clk);
		#1 chk(reg_rdata, 8'h00);
		rd(CFG_B_ADDR, CFG_RESET);
		rd(STATUS_ADDR, 8'h04);
		rd(8'h05, 8'h00);
		wr(STATUS_ADDR, 8'hFF);
		wr(8'h07, 8'hFF);
		@(posedge clk);
		ce <= 1'b0;
		wr(CFG_A_ADDR, 8'hFF);
		ce <= 1'b1;
		rd(CFG_A_ADDR, CFG_RESET);
		foreach (rows[i]) begin
			@(posedge clk);
			setpoint <= rows[i].sp;
			pins <= rows[i].pins;
			wr(CFG_A_ADDR, rows[i].a);
			wr(CFG_B_ADDR, rows[i].b);
			repeat (2) @(posedge clk);
			#1 chk(vout_target_code, rows[i].vout);
			chk({4'h0, phase_idx}, {4'h0, rows[i].ph});
			chk({6'h0, phase_valid}, {6'h0, rows[i].pv});
			chk({7'h0, loop_test_enable}, {7'h0, rows[i].lp});
			chk({7'h0, latchoff_enable}, {7'h0, rows[i].le});
			rd(CFG_B_ADDR, rows[i].b);
		end
		// Latch enabled from B only; timeout must run its full count
		@(posedge clk);
		current_limit_active <= 1'b1;
		repeat (TMO - 1) @(posedge clk);
		#1 chk({7'h0, latched_off}, 8'h00);
		@(posedge clk);
		#1 chk({7'h0, latched_off}, 8'h01);
		rd(STATUS_ADDR, 8'h2D);
		@(posedge clk);
		current_limit_active <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk({7'h0, latched_off}, 8'h01);
		wr_rd(CFG_B_ADDR, 8'h5C);
		@(posedge clk);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		wr(CFG_A_ADDR, 8'h00);
		wr(CFG_B_ADDR, 8'h00);
		current_limit_active <= 1'b1;
		repeat (4 * TMO) @(posedge clk);
		#1 chk({7'h0, latched_off}, 8'h00);
		chk({7'h0, latchoff_enable}, 8'h00);
		complete_run();
	end
endmodule : tb_rcp_regulator_config
`default_nettype wire
